// >>> rtl/fps_top.sv
`timescale 1ns/1ps
module fps_top
  import fps_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        mask_rom,
  input  wire logic        rom_fetch,
  input  wire logic        op_fault,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             flash_busy,
  output logic             rom_protect_active
);
  typedef struct packed {
    fps_state_t           state;
    logic [7:0]           cnt;
    logic                 fault_seen;
    logic [FPS_AW-1:0]    maddr;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 rd_mem;
    logic                 flash_busy;
    logic                 prot_act;
    logic                 lock_armed;
  } fps_top_t;
  fps_top_t s;
  fps_top_t next_s;
  logic        prot_en;
  // Block bits live in the power-on domain, apart from the bus state
  logic [FPS_NBLK-1:0] blk;
  logic [FPS_NBLK-1:0] next_blk;
  logic        pe_load;
  logic        pe_value;
  logic        mem_we;
  logic [31:0] mem_rdata;
  logic        setup;
  logic        wr;
  logic        full_word;
  logic        guard_ok;
  logic        prot_live;
  logic [31:0] stat_word;
  logic [31:0] cmd;

  function automatic logic is_addr(input logic [31:0] a, input logic [31:0] r);
    is_addr = (a == r);
  endfunction : is_addr

  assign setup     = psel && !penable;
  assign wr        = setup && pwrite;
  assign full_word = (pstrb == 4'hF);
  assign cmd       = pwdata;
  assign prot_live = prot_en && (blk == FPS_BLK_RESET);
  // Protect and lock registers guarded by fetch origin when protected
  assign guard_ok  = !prot_live || rom_fetch;

  always_comb
  begin
    stat_word = 32'h00000000;
    stat_word[FPS_RDY_BIT] = (s.state == FPS_IDLE);
    stat_word[FPS_ROMKIND_BIT] = mask_rom;
    stat_word[FPS_BLK_LSB +: FPS_NBLK] = blk;
  end

  always_comb
  begin
    next_s         = s;
    next_blk       = blk;
    pe_load        = 1'b0;
    pe_value       = 1'b0;
    mem_we         = 1'b0;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.rd_mem  = 1'b0;
    // Auto operation timer
    unique case (s.state)
      FPS_IDLE:
      begin
        next_s.cnt = 8'h00;
      end
      FPS_BUSY:
      begin
        if (op_fault)
        begin
          next_s.state = FPS_FAULT;
        end
        else if (s.cnt == 8'(FPS_OP_CYCLES - 1))
        begin
          next_s.state = FPS_IDLE;
        end
        else
        begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      FPS_FAULT:
      begin
        next_s.cnt = 8'h00;
      end
    endcase
    if (setup)
    begin
      next_s.pready = 1'b1;
      if (pwrite)
      begin
        if (is_addr(paddr, FPS_ADDR_ROM_PROT))
        begin
          if (guard_ok && full_word)
          begin
            pe_load  = 1'b1;
            pe_value = pwdata[FPS_PROT_EN_BIT];
            next_s.lock_armed = 1'b1;
          end
          else
          begin
            next_s.pslverr = 1'b1;
          end
        end
        else if (is_addr(paddr, FPS_ADDR_ROM_LOCK))
        begin
          if (guard_ok && full_word && s.lock_armed && (pwdata == FPS_LOCK_KEY))
          begin
            next_s.lock_armed = 1'b0;
          end
          else if (!guard_ok)
          begin
            next_s.pslverr = 1'b1;
          end
        end
        else if (is_addr(paddr, FPS_ADDR_FLASH_STAT))
        begin
          next_s.pready = 1'b1;
        end
        else if (is_addr(paddr, FPS_ADDR_MEM_ADDR))
        begin
          next_s.maddr = pwdata[FPS_AW-1:0];
        end
        else if (is_addr(paddr, FPS_ADDR_FLASH_CTRL))
        begin
          if (cmd[1:0] == FPS_CMD_RESET)
          begin
            next_s.state = FPS_IDLE;
          end
          else if (s.state != FPS_IDLE)
          begin
            next_s.pslverr = 1'b1;
          end
          else if (cmd[1:0] == FPS_CMD_PROTECT)
          begin
            // Loads all four block bits; a zero releases that block on flash parts, mask parts keep all four set
            next_blk     = cmd[FPS_BLK_LSB +: FPS_NBLK];
            next_s.state = FPS_BUSY;
          end
          else if (cmd[1:0] == FPS_CMD_PROG)
          begin
            next_s.state = FPS_BUSY;
          end
        end
        else if (is_addr(paddr, FPS_ADDR_MEM_DATA))
        begin
          // Block index from top address bits; protected blocks refuse
          if (blk[s.maddr[FPS_AW-1 -: 2]] || (s.state != FPS_IDLE))
          begin
            next_s.pslverr = 1'b1;
          end
          else
          begin
            mem_we       = 1'b1;
            next_s.state = FPS_BUSY;
          end
        end
        else
        begin
          next_s.pslverr = 1'b1;
        end
      end
      else
      begin
        next_s.prdata = 32'h00000000;
        if (is_addr(paddr, FPS_ADDR_ROM_PROT))
        begin
          if (guard_ok)
          begin
            next_s.prdata[FPS_PROT_EN_BIT] = prot_en;
          end
          else
          begin
            next_s.pslverr = 1'b1;
          end
        end
        else if (is_addr(paddr, FPS_ADDR_FLASH_STAT))
        begin
          next_s.prdata = stat_word;
        end
        else if (is_addr(paddr, FPS_ADDR_MEM_ADDR))
        begin
          next_s.prdata[FPS_AW-1:0] = s.maddr;
        end
        else if (is_addr(paddr, FPS_ADDR_MEM_DATA))
        begin
          next_s.pready = 1'b0;
          next_s.rd_mem = 1'b1;
        end
        else if (is_addr(paddr, FPS_ADDR_ROM_LOCK) || is_addr(paddr, FPS_ADDR_FLASH_CTRL))
        begin
          next_s.prdata = 32'h00000000;
        end
        else
        begin
          next_s.pslverr = 1'b1;
        end
      end
    end
    // Memory read data is one cycle late out of its register
    if (s.rd_mem)
    begin
      next_s.prdata = mem_rdata;
      next_s.pready = 1'b1;
    end
    next_s.flash_busy = (next_s.state != FPS_IDLE);
    next_s.prot_act   = prot_live;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s.state      <= FPS_IDLE;
      s.cnt        <= 8'h00;
      s.fault_seen <= 1'b0;
      s.maddr      <= '0;
      s.prdata     <= 32'h00000000;
      s.pready     <= 1'b0;
      s.pslverr    <= 1'b0;
      s.rd_mem     <= 1'b0;
      s.flash_busy <= 1'b0;
      s.prot_act   <= 1'b0;
      s.lock_armed <= 1'b0;
    end
    else
    begin
      s.state      <= next_s.state;
      s.cnt        <= next_s.cnt;
      s.fault_seen <= next_s.fault_seen;
      s.maddr      <= next_s.maddr;
      s.prdata     <= next_s.prdata;
      s.pready     <= next_s.pready;
      s.pslverr    <= next_s.pslverr;
      s.rd_mem     <= next_s.rd_mem;
      s.flash_busy <= next_s.flash_busy;
      s.prot_act   <= next_s.prot_act;
      s.lock_armed <= next_s.lock_armed;
    end
  end

  // Block protect bits are nonvolatile: power-on only, reset value all set
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      blk <= FPS_BLK_RESET;
    end
    else
    begin
      blk <= mask_rom ? FPS_BLK_RESET : next_blk;
    end
  end

  fps_keep u_keep (
    .pclk    (pclk),
    .por_n   (por_n),
    .presetn (presetn),
    .mask_rom(mask_rom),
    .load    (pe_load),
    .value   (pe_value),
    .prot_en (prot_en)
  );

  fps_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .addr    (s.maddr),
    .wdata   (pwdata),
    .rdata   (mem_rdata)
  );

  assign prdata             = s.prdata;
  assign pready             = s.pready;
  assign pslverr            = s.pslverr;
  assign flash_busy         = s.flash_busy;
  assign rom_protect_active = s.prot_act;
endmodule : fps_top

// >>> rtl/fps_pkg.sv
package fps_pkg;
  localparam logic [31:0] FPS_ADDR_ROM_PROT    = 32'hFFFFE518;
  localparam logic [31:0] FPS_ADDR_ROM_LOCK    = 32'hFFFFE51C;
  localparam logic [31:0] FPS_ADDR_FLASH_STAT  = 32'hFFFFE520;
  localparam logic [31:0] FPS_ADDR_FLASH_CTRL  = 32'hFFFFE524;
  localparam logic [31:0] FPS_ADDR_MEM_ADDR    = 32'hFFFFE528;
  localparam logic [31:0] FPS_ADDR_MEM_DATA    = 32'hFFFFE52C;
  localparam int          FPS_RDY_BIT          = 0;
  localparam int          FPS_ROMKIND_BIT      = 2;
  localparam int          FPS_BLK_LSB          = 4;
  localparam int          FPS_NBLK             = 4;
  localparam int          FPS_PROT_EN_BIT      = 0;
  localparam logic [31:0] FPS_LOCK_KEY         = 32'h0000003D;
  localparam logic        FPS_PROT_EN_RESET    = 1'b1;
  localparam logic [3:0]  FPS_BLK_RESET        = 4'hF;
  localparam int          FPS_WORDS            = 16;
  localparam int          FPS_AW               = 4;
  localparam int          FPS_OP_CYCLES        = 8;
  localparam logic [1:0]  FPS_CMD_PROG         = 2'h1;
  localparam logic [1:0]  FPS_CMD_PROTECT      = 2'h2;
  localparam logic [1:0]  FPS_CMD_RESET        = 2'h3;
  typedef enum logic [1:0] {FPS_IDLE, FPS_BUSY, FPS_FAULT} fps_state_t;
endpackage : fps_pkg

// >>> rtl/fps_mem.sv
`timescale 1ns/1ps
module fps_mem
  import fps_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              we,
  input  wire logic [FPS_AW-1:0] addr,
  input  wire logic [31:0]       wdata,
  output logic      [31:0]       rdata
);
  typedef struct packed {
    logic [FPS_WORDS-1:0][31:0] mem;
    logic [31:0]                rdata;
  } fps_mem_t;
  fps_mem_t s;
  fps_mem_t next_s;
  always_comb
  begin
    next_s = s;
    if (we)
    begin
      next_s.mem[addr] = wdata;
    end
    next_s.rdata = s.mem[addr];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
  assign rdata = s.rdata;
endmodule : fps_mem

// >>> rtl/fps_keep.sv
`timescale 1ns/1ps
module fps_keep
  import fps_pkg::*;
(
  input  wire logic pclk,
  input  wire logic por_n,
  input  wire logic presetn,
  input  wire logic mask_rom,
  input  wire logic load,
  input  wire logic value,
  output logic      prot_en
);
  typedef struct packed {
    logic prot_en;
  } fps_keep_t;
  fps_keep_t s;
  fps_keep_t next_s;
  logic      rst_n;
  // Mask parts set protect-enable on every reset, flash parts only on power-on
  assign rst_n = mask_rom ? (por_n & presetn) : por_n;
  always_comb
  begin
    next_s = s;
    if (load)
    begin
      next_s.prot_en = value;
    end
  end
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s.prot_en <= FPS_PROT_EN_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end
  assign prot_en = s.prot_en;
endmodule : fps_keep

// >>> tb/fps_top_asserts.sv
`timescale 1ns/1ps
module fps_top_asserts
  import fps_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        op_fault,
  input wire logic        rom_fetch,
  input wire logic        mask_rom,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_busy,
  input wire logic        rom_protect_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup;
  assign setup = psel && !penable;
  property p_answer;
    setup |=> ##[0:1] pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer to request");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmap;
    setup && (paddr < FPS_ADDR_ROM_PROT || paddr > FPS_ADDR_MEM_DATA) |=> pready && pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_stat_wr;
    setup && pwrite && paddr == FPS_ADDR_FLASH_STAT |=> pready && !pslverr;
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write refused");
  property p_stat_rd;
    pready && psel && !pwrite && paddr == FPS_ADDR_FLASH_STAT |-> prdata[31:8] == 24'h0 && !prdata[3] && !prdata[1]
      && prdata[2] == mask_rom;
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("bad status fields");
  property p_lock;
    setup && rom_protect_active && !rom_fetch && paddr == FPS_ADDR_ROM_PROT |=> pready && pslverr;
  endproperty
  a_lock: assert property (p_lock) else $error("locked register reachable");
  property p_narrow;
    setup && pwrite && pstrb != 4'hF && paddr == FPS_ADDR_ROM_PROT |=> pslverr;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow write taken");
  property p_busy;
    $rose(flash_busy) && !op_fault |-> flash_busy[*8];
  endproperty
  a_busy: assert property (p_busy) else $error("busy too short");
  property p_fault;
    flash_busy && op_fault && !psel |=> flash_busy;
  endproperty
  a_fault: assert property (p_fault) else $error("fault cleared busy");
  property p_rst;
    $rose(presetn) |-> !flash_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_prot_rd;
    pready && psel && !pwrite && !pslverr && paddr == FPS_ADDR_ROM_PROT |-> prdata[31:1] == 31'h0;
  endproperty
  a_prot_rd: assert property (p_prot_rd) else $error("reserved bits set");
endmodule : fps_top_asserts

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb
  import fps_pkg::*;
;
  logic pclk = 0, presetn = 0, por_n = 0, mask_rom = 0, rom_fetch = 0, op_fault = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, flash_busy, rom_protect_active;
  logic [31:0] paddr = 0, pwdata = 0, prdata, got, old;
  logic [3:0]  pstrb = 4'hF;
  int n_errors = 0, num_checks = 0, cycles = 0;
  fps_top u_dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .mask_rom(mask_rom), .rom_fetch(rom_fetch),
    .op_fault(op_fault), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_busy(flash_busy),
    .rom_protect_active(rom_protect_active));
  always #10 pclk = ~pclk;
  task stop_test;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic e);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    got = prdata;
    chk({31'h0, pslverr}, {31'h0, e});
    psel <= 0; penable <= 0;
  endtask : acc
  task wait_ready;
    got = 0;
    while (got[0] !== 1'b1)
      acc(0, FPS_ADDR_FLASH_STAT, 0, 4'hF, 0);
  endtask : wait_ready
  task rst(input logic por);
    @(posedge pclk);
    presetn <= 0;
    if (por)
      por_n <= 0;
    repeat (5) @(posedge pclk);
    presetn <= 1; por_n <= 1;
  endtask : rst
  initial
  begin
    rst(1);
    acc(0, FPS_ADDR_FLASH_STAT, 0, 4'hF, 0); chk(got, 32'h000000F1);
    acc(1, FPS_ADDR_FLASH_STAT, 32'hFFFFFFFF, 4'hF, 0);
    acc(0, FPS_ADDR_FLASH_STAT, 0, 4'hF, 0); chk(got, 32'h000000F1);
    chk({31'h0, rom_protect_active}, 1);
    acc(0, FPS_ADDR_ROM_PROT, 0, 4'hF, 1);
    rom_fetch <= 1;
    acc(0, FPS_ADDR_ROM_PROT, 0, 4'hF, 0); chk(got, 1);
    acc(1, FPS_ADDR_ROM_PROT, 0, 4'h3, 1);
    acc(0, 32'hFFFFE530, 0, 4'hF, 1);
    acc(1, FPS_ADDR_MEM_ADDR, 0, 4'hF, 0);
    acc(0, FPS_ADDR_MEM_DATA, 0, 4'hF, 0); old = got;
    acc(1, FPS_ADDR_MEM_DATA, 32'hA5A5A5A5, 4'hF, 1);
    acc(0, FPS_ADDR_MEM_DATA, 0, 4'hF, 0); chk(got, old);
    acc(1, FPS_ADDR_ROM_PROT, 0, 4'hF, 0); acc(0, FPS_ADDR_ROM_PROT, 0, 4'hF, 0); chk(got, 0);
    chk({31'h0, rom_protect_active}, 0);
    acc(1, FPS_ADDR_FLASH_CTRL, {30'h0, FPS_CMD_PROTECT}, 4'hF, 0);
    acc(0, FPS_ADDR_FLASH_STAT, 0, 4'hF, 0); chk({31'h0, got[0]}, 0);
    wait_ready(); chk(got, 32'h00000001);
    acc(1, FPS_ADDR_MEM_DATA, 32'hA5A5A5A5, 4'hF, 0);
    wait_ready();
    acc(0, FPS_ADDR_MEM_DATA, 0, 4'hF, 0); chk(got, 32'hA5A5A5A5);
    acc(1, FPS_ADDR_FLASH_CTRL, {30'h0, FPS_CMD_PROG}, 4'hF, 0);
    op_fault <= 1;
    repeat (12) @(posedge pclk);
    op_fault <= 0;
    acc(0, FPS_ADDR_FLASH_STAT, 0, 4'hF, 0); chk({31'h0, got[0]}, 0);
    chk({31'h0, flash_busy}, 1);
    acc(1, FPS_ADDR_FLASH_CTRL, {30'h0, FPS_CMD_RESET}, 4'hF, 0);
    wait_ready(); chk({31'h0, got[0]}, 1);
    acc(1, FPS_ADDR_FLASH_CTRL, {30'h0, FPS_CMD_PROG}, 4'hF, 0);
    op_fault <= 1;
    repeat (12) @(posedge pclk);
    op_fault <= 0;
    rst(0);
    acc(0, FPS_ADDR_FLASH_STAT, 0, 4'hF, 0); chk({31'h0, got[0]}, 1);
    acc(0, FPS_ADDR_ROM_PROT, 0, 4'hF, 0); chk(got, 0);
    mask_rom <= 1;
    rst(1);
    acc(0, FPS_ADDR_FLASH_STAT, 0, 4'hF, 0); chk(got, 32'h000000F5);
    rom_fetch <= 0;
    acc(1, FPS_ADDR_ROM_LOCK, FPS_LOCK_KEY, 4'hF, 1);
    rom_fetch <= 1;
    acc(1, FPS_ADDR_ROM_PROT, 0, 4'hF, 0);
    acc(1, FPS_ADDR_ROM_LOCK, FPS_LOCK_KEY, 4'hF, 0);
    rst(0);
    acc(0, FPS_ADDR_ROM_PROT, 0, 4'hF, 0); chk(got, 1);
    stop_test();
  end
endmodule : tb
bind fps_top fps_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .op_fault(op_fault), .rom_fetch(rom_fetch),
  .mask_rom(mask_rom), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_busy(flash_busy),
  .rom_protect_active(rom_protect_active));
